// [rtl/tic_pkg.sv]
// shared constants and types of the time interval counter
package tic_pkg;

	// --------------------------------------------------------------
	// bus shapes
	// --------------------------------------------------------------
	typedef logic [11:0] addr_t;
	typedef logic [31:0] data_t;
	typedef logic [9:0]  index_t;
	typedef logic [7:0]  byte_t;

	// register indices; byte address is four times the index
	localparam index_t IDX_CONTROL = 10'h0A1;
	localparam index_t IDX_TICK    = 10'h0A2;
	localparam index_t IDX_SECOND  = 10'h0A3;
	localparam index_t IDX_MINUTE  = 10'h0A4;
	localparam index_t IDX_HOUR    = 10'h0A5;
	localparam index_t IDX_COMPARE = 10'h0A6;
	localparam index_t IDX_STATUS  = 10'h0A7;
	localparam index_t IDX_MASK    = 10'h0A8;

	// --------------------------------------------------------------
	// field layouts and values
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		RATE_TICK   = 2'h0,
		RATE_SECOND = 2'h1,
		RATE_MINUTE = 2'h2,
		RATE_HOUR   = 2'h3
	} rate_sel_t;

	typedef struct packed {
		logic reserved;
		logic day_wrap_select;
		logic interval_rate_select_hi;
		logic interval_rate_select_lo;
		logic one_shot_interval;
		logic interval_match_flag;
		logic interval_run_enable;
		logic timebase_run_enable;
	} timebase_control_t;

	localparam timebase_control_t CONTROL_RST = 8'h00;
	localparam byte_t  REG_RST        = 8'h00;
	localparam byte_t  ZERO           = 8'h00;
	localparam byte_t  ONE            = 8'h01;
	localparam byte_t  TICK_MAX       = 8'h7F;
	localparam byte_t  SECOND_MAX     = 8'h3B;
	localparam byte_t  MINUTE_MAX     = 8'h3B;
	localparam byte_t  HOUR_DAY_MAX   = 8'h17;
	localparam byte_t  HOUR_FULL_MAX  = 8'hFF;
	localparam int     STAT_MATCH_BIT = 0;
	localparam int     TALLIES        = 4;

	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int unsigned XTAL_HZ   = 32768;
	localparam int unsigned TICK_HZ   = 128;
	localparam int unsigned DIV_COUNT = XTAL_HZ / TICK_HZ;
	localparam logic [7:0]  DIV_ZERO  = 8'h00;
	localparam logic [7:0]  DIV_ONE   = 8'h01;
	localparam logic [7:0]  DIV_MAX   = 8'(DIV_COUNT - 1);

endpackage

// [rtl/tic_tick_div.sv]
// crystal synchroniser and divider that makes the 1/128 s tick
`timescale 1ns/1ps
module tic_tick_div (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// crystal and control
	input  wire logic xtal_in,
	input  wire logic run,
	// tick out
	output logic      tick
);
	import tic_pkg::*;

	logic       sync1_q;
	logic       sync2_q;
	logic       prev_q;
	logic       rise;
	logic [7:0] div_q;

	// --------------------------------------------------------------
	// crystal crossing
	// --------------------------------------------------------------
	// two flops, then a third stage for the edge; only sync2 reads sync1
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q  <= 1'b0;
		end else begin
			sync1_q <= xtal_in;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	assign rise = sync2_q & ~prev_q;

	// --------------------------------------------------------------
	// divide by 256
	// --------------------------------------------------------------
	// cleared while stopped so the first tick is a full period late
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= DIV_ZERO;
		end else if (!run) begin
			div_q <= DIV_ZERO;
		end else if (rise) begin
			div_q <= div_q + DIV_ONE;
		end
	end

	// one pulse per wrap of the divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick <= 1'b0;
		end else begin
			tick <= run & rise & (div_q == DIV_MAX);
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_tick_on_wrap;
		tick |-> $past(div_q) == DIV_MAX && $past(rise) && $past(run);
	endproperty
	a_tick_on_wrap: assert property (p_tick_on_wrap)
		else $error("tick without divider wrap");

	property p_div_holds;
		run && !rise |=> $stable(div_q) || !$past(run);
	endproperty
	a_div_holds: assert property (p_div_holds)
		else $error("divider moved without crystal edge");

endmodule

// [rtl/time_interval_counter.sv]
// time-of-day tally chain with interval alarm behind an apb slave
`timescale 1ns/1ps

module time_interval_counter (
	// clock and reset
	input  wire logic           pclk,
	input  wire logic           presetn,
	// apb slave
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire tic_pkg::addr_t paddr,
	input  wire tic_pkg::data_t pwdata,
	output tic_pkg::data_t      prdata,
	output logic                pready,
	output logic                pslverr,
	// crystal pin
	input  wire logic           xtal_in,
	// interrupt
	output logic                irq
);
	import tic_pkg::*;

	timebase_control_t ctrl_q;
	byte_t             tally_q  [TALLIES];
	byte_t             shadow_q [TALLIES];
	byte_t             top      [TALLIES];
	logic              wrap     [TALLIES];
	logic              wr_time  [TALLIES];
	logic [TALLIES:0]  carry;
	byte_t             cmp_q;
	byte_t             ivl_q;
	byte_t             ivl_next;
	byte_t             mask_q;
	byte_t             status;
	logic              tick;
	logic              run;
	logic              ivl_ev;
	logic              ivl_hit;
	logic              acc_req;
	logic              wr;
	index_t            idx;
	logic              wr_ctrl;
	logic              wr_cmp;
	logic              wr_stat;
	logic              wr_mask;
	data_t             rd_d;
	logic              hit_d;
	rate_sel_t         rate;

	// --------------------------------------------------------------
	// tick source
	// --------------------------------------------------------------
	tic_tick_div u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.xtal_in (xtal_in),
		.run     (ctrl_q.timebase_run_enable),
		.tick    (tick)
	);

	// --------------------------------------------------------------
	// apb decode
	// --------------------------------------------------------------
	// one wait state: pready rises in the second access cycle
	assign acc_req = psel & penable;
	assign wr      = acc_req & pready & pwrite;
	assign idx     = paddr[11:2];
	assign wr_ctrl = wr & (idx == IDX_CONTROL);
	assign wr_cmp  = wr & (idx == IDX_COMPARE);
	assign wr_stat = wr & (idx == IDX_STATUS);
	assign wr_mask = wr & (idx == IDX_MASK);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= acc_req & ~pready;
		end
	end

	// read data and error are loaded together with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= (acc_req & ~pready & ~pwrite) ? rd_d : '0;
			pslverr <= acc_req & ~pready & ~hit_d;
		end
	end

	// read mux; unmapped words read zero and flag an error
	always_comb begin
		rd_d  = '0;
		hit_d = 1'b1;
		case (idx)
			IDX_CONTROL: rd_d[7:0] = ctrl_q;
			IDX_TICK:    rd_d[7:0] = tally_q[0];
			IDX_SECOND:  rd_d[7:0] = tally_q[1];
			IDX_MINUTE:  rd_d[7:0] = tally_q[2];
			IDX_HOUR:    rd_d[7:0] = tally_q[3];
			IDX_COMPARE: rd_d[7:0] = cmp_q;
			IDX_STATUS:  rd_d[7:0] = status;
			IDX_MASK:    rd_d[7:0] = mask_q;
			default:     hit_d     = 1'b0;
		endcase
	end

	// --------------------------------------------------------------
	// tally chain
	// --------------------------------------------------------------
	assign run      = ctrl_q.timebase_run_enable;
	assign carry[0] = tick & run;
	assign top[0]   = TICK_MAX;
	assign top[1]   = SECOND_MAX;
	assign top[2]   = MINUTE_MAX;
	// full mode simply lets the byte roll over at 255
	assign top[3]   = ctrl_q.day_wrap_select ? HOUR_DAY_MAX
	                                         : HOUR_FULL_MAX;

	genvar g;
	generate
		for (g = 0; g < TALLIES; g++) begin : g_tally
			assign wrap[g]     = tally_q[g] == top[g];
			assign carry[g+1]  = carry[g] & wrap[g];
			// writes only land while the clock is stopped
			assign wr_time[g]  = wr & ~run &
			                     (idx == IDX_TICK + 10'(g));

			// last value written, restored on every stop
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					shadow_q[g] <= REG_RST;
				end else if (wr_time[g]) begin
					shadow_q[g] <= pwdata[7:0];
				end
			end

			// a value written above top runs on to 255 first
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					tally_q[g] <= REG_RST;
				end else if (!run) begin
					tally_q[g] <= wr_time[g] ? pwdata[7:0]
					                         : shadow_q[g];
				end else if (carry[g]) begin
					tally_q[g] <= wrap[g] ? ZERO : tally_q[g] + ONE;
				end
			end
		end
	endgenerate

	// --------------------------------------------------------------
	// interval counter
	// --------------------------------------------------------------
	assign rate = rate_sel_t'({ctrl_q.interval_rate_select_hi,
	                           ctrl_q.interval_rate_select_lo});

	// pick which overflow clocks the interval counter
	always_comb begin
		unique case (rate)
			RATE_TICK:   ivl_ev = carry[0];
			RATE_SECOND: ivl_ev = carry[1];
			RATE_MINUTE: ivl_ev = carry[2];
			RATE_HOUR:   ivl_ev = carry[3];
		endcase
	end

	assign ivl_next = ivl_q + ONE;
	// compare on the next value so a compare of n means n steps
	assign ivl_hit  = ctrl_q.interval_run_enable & ivl_ev &
	                  (ivl_next == cmp_q);

	// held at zero when disabled; a timeout reloads zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ivl_q <= REG_RST;
		end else if (!ctrl_q.interval_run_enable || ivl_hit) begin
			ivl_q <= ZERO;
		end else if (ivl_ev) begin
			ivl_q <= ivl_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_q <= REG_RST;
		end else if (wr_cmp) begin
			cmp_q <= pwdata[7:0];
		end
	end

	// --------------------------------------------------------------
	// control register
	// --------------------------------------------------------------
	// a software write wins over the one-shot clear of the enable; the
	// flag is assigned last so the whole-word write never reaches it,
	// and its set beats a same-cycle write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CONTROL_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= timebase_control_t'({1'b0, pwdata[6:0]});
			end else if (ivl_hit && ctrl_q.one_shot_interval) begin
				ctrl_q.interval_run_enable <= 1'b0;
			end
			ctrl_q.interval_match_flag <= ivl_hit |
				(ctrl_q.interval_match_flag &
				 ~(wr_stat & pwdata[STAT_MATCH_BIT]));
		end
	end

	// --------------------------------------------------------------
	// status, mask and interrupt
	// --------------------------------------------------------------

	always_comb begin
		status                 = ZERO;
		status[STAT_MATCH_BIT] = ctrl_q.interval_match_flag;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= REG_RST;
		end else if (wr_mask) begin
			mask_q <= pwdata[7:0];
		end
	end

	// level output, one flop after the flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask_q);
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_match_irq;
		ctrl_q.interval_match_flag ##1 irq;
	endsequence
	property p_match_irq;
		ivl_hit && mask_q[STAT_MATCH_BIT] && !wr_mask |=> s_match_irq;
	endproperty
	a_match_irq: assert property (p_match_irq)
		else $error("match did not raise flag and irq");
	property p_tick_step;
		carry[0] && !wrap[0] |=> tally_q[0] == $past(tally_q[0]) + ONE;
	endproperty
	a_tick_step: assert property (p_tick_step)
		else $error("sub-second tally did not step");
	property p_tick_wrap;
		carry[1] && !wrap[1] |=>
			tally_q[0] == ZERO && tally_q[1] == $past(tally_q[1]) + ONE;
	endproperty
	a_tick_wrap: assert property (p_tick_wrap)
		else $error("sub-second rollover wrong");
	property p_sec_wrap;
		carry[2] |=> tally_q[1] == ZERO && tally_q[0] == ZERO;
	endproperty
	a_sec_wrap: assert property (p_sec_wrap)
		else $error("seconds rollover wrong");
	property p_min_wrap;
		carry[3] |=> tally_q[2] == ZERO;
	endproperty
	a_min_wrap: assert property (p_min_wrap)
		else $error("minutes rollover wrong");
	sequence s_day_end;
		carry[3] && ctrl_q.day_wrap_select &&
			tally_q[3] == HOUR_DAY_MAX;
	endsequence
	property p_day_wrap;
		s_day_end |=> tally_q[3] == ZERO;
	endproperty
	a_day_wrap: assert property (p_day_wrap)
		else $error("hours did not wrap after 23");
	property p_full_hours;
		carry[3] && !ctrl_q.day_wrap_select &&
			tally_q[3] == HOUR_DAY_MAX |=> tally_q[3] == HOUR_DAY_MAX + ONE;
	endproperty
	a_full_hours: assert property (p_full_hours)
		else $error("hours wrapped in full mode");
	property p_rate_gate;
		ctrl_q.interval_run_enable && !ivl_ev && !wr_ctrl |=>
			$stable(ivl_q);
	endproperty
	a_rate_gate: assert property (p_rate_gate)
		else $error("interval counter moved without its overflow");
	property p_stop_restore;
		!run |=> tally_q[0] == shadow_q[0] && tally_q[1] == shadow_q[1] &&
			tally_q[2] == shadow_q[2] && tally_q[3] == shadow_q[3];
	endproperty
	a_stop_restore: assert property (p_stop_restore)
		else $error("stopped tallies differ from written values");
	property p_run_locks;
		run && wr |=> $stable(shadow_q[0]) && $stable(shadow_q[3]);
	endproperty
	a_run_locks: assert property (p_run_locks)
		else $error("time written while running");
	sequence s_oneshot_hit;
		ivl_hit && ctrl_q.one_shot_interval && !wr_ctrl;
	endsequence
	property p_oneshot;
		s_oneshot_hit |=> !ctrl_q.interval_run_enable ##1 ivl_q == ZERO;
	endproperty
	a_oneshot: assert property (p_oneshot)
		else $error("one-shot did not stop interval counter");
	property p_reload;
		ivl_hit && !ctrl_q.one_shot_interval && !wr_ctrl |=>
			ctrl_q.interval_run_enable && ivl_q == ZERO;
	endproperty
	a_reload: assert property (p_reload)
		else $error("interval counter did not reload");

endmodule

// [test/time_interval_counter_tb_top.sv]
// self-checking bench for the time interval counter over apb
`timescale 1ns/1ps
module time_interval_counter_tb_top;
	import tic_pkg::*;

	// ----------------------------------------------------------
	// clock, reset, crystal and bus signals
	// ----------------------------------------------------------
	localparam int XHALF = 3;
	localparam int XT    = 512 * XHALF;
	logic  pclk;
	logic  presetn;
	logic  psel;
	logic  penable;
	logic  pwrite;
	addr_t paddr;
	data_t pwdata;
	data_t prdata;
	logic  pready;
	logic  pslverr;
	logic  xtal_in;
	logic  irq;
	int    xcnt;
	int    cyc;
	int    t0;
	int    bad_count;
	int    tests_run;

	time_interval_counter u_dut (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.xtal_in (xtal_in),
		.irq     (irq)
	);

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// crystal runs free, toggling every XHALF pclk cycles, a third of the rate the synchroniser takes
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		xcnt <= (xcnt == XHALF - 1) ? 0 : xcnt + 1;
		if (xcnt == XHALF - 1) begin
			xtal_in <= ~xtal_in;
		end
	end

	// ----------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------
	task automatic check(input byte_t seen, input byte_t exp,
		input string what);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t %s seen %h exp %h", $time, what,
				seen, exp);
		end
	endtask

	// one apb transfer; waits for pready, never for a fixed count
	task automatic bus(input logic wr, input index_t idx,
		input byte_t wd, output byte_t rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			check(ZERO, ONE, "no pready");
		end
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input index_t idx, input byte_t v);
		byte_t d;
		logic  e;
		bus(1'b1, idx, v, d, e);
	endtask

	task automatic rdchk(input index_t idx, input byte_t exp,
		input string what);
		byte_t d;
		logic  e;
		bus(1'b0, idx, ZERO, d, e);
		check(d, exp, what);
	endtask

	// start the timebase; ticks are counted from this write
	task automatic go(input byte_t c);
		wr(IDX_CONTROL, c);
		t0 = cyc;
	endtask

	// margin keeps reads well clear of the next tick
	task automatic wait_tick(input int k);
		while (cyc < t0 + k * XT + 200) @(posedge pclk);
	endtask

	task automatic preset(input byte_t t, input byte_t s,
		input byte_t m, input byte_t h);
		wr(IDX_CONTROL, ZERO);
		wr(IDX_STATUS, ONE);
		wr(IDX_TICK, t);
		wr(IDX_SECOND, s);
		wr(IDX_MINUTE, m);
		wr(IDX_HOUR, h);
	endtask

	// ----------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------
	task automatic reset_map();
		byte_t d;
		logic  e;
		for (int i = 0; i < 8; i++) begin
			rdchk(index_t'(IDX_CONTROL + i), ZERO, "reset value");
		end
		bus(1'b0, 10'h0A9, ZERO, d, e);
		check({7'h00, e}, ONE, "unmapped error");
		check(d, ZERO, "unmapped data");
	endtask

	task automatic day_rollover();
		preset(TICK_MAX, SECOND_MAX, MINUTE_MAX, HOUR_DAY_MAX);
		rdchk(IDX_SECOND, SECOND_MAX, "written while stopped");
		go(8'h41);
		wait_tick(1);
		rdchk(IDX_TICK, ZERO, "sub-second wrap");
		rdchk(IDX_SECOND, ZERO, "seconds wrap");
		rdchk(IDX_MINUTE, ZERO, "minutes wrap");
		rdchk(IDX_HOUR, ZERO, "day hours wrap");
		wr(IDX_SECOND, 8'h05);
		rdchk(IDX_SECOND, ZERO, "write while running");
		wr(IDX_CONTROL, ZERO);
		rdchk(IDX_HOUR, HOUR_DAY_MAX, "restore on stop");
		rdchk(IDX_TICK, TICK_MAX, "restore on stop");
		rdchk(IDX_SECOND, SECOND_MAX, "running write kept out");
	endtask

	task automatic full_hours();
		byte_t hv[2];
		byte_t he[2];
		hv = '{8'h17, 8'hFF};
		he = '{8'h18, 8'h00};
		for (int i = 0; i < 2; i++) begin
			preset(TICK_MAX, SECOND_MAX, MINUTE_MAX, hv[i]);
			go(8'h01);
			wait_tick(1);
			rdchk(IDX_HOUR, he[i], "full hours");
		end
	endtask

	// compare 2 at tick rate: continuous, masked, then one-shot
	task automatic interval_alarm();
		preset(ZERO, ZERO, ZERO, ZERO);
		wr(IDX_COMPARE, 8'h02);
		wr(IDX_MASK, ONE);
		go(8'h03);
		wait_tick(1);
		rdchk(IDX_TICK, ONE, "one tick");
		rdchk(IDX_STATUS, ZERO, "no early match");
		wait_tick(2);
		rdchk(IDX_TICK, 8'h02, "two ticks");
		rdchk(IDX_STATUS, ONE, "match flag");
		check({7'h00, irq}, ONE, "irq raised");
		rdchk(IDX_CONTROL, 8'h07, "reload keeps enable");
		wr(IDX_STATUS, ONE);
		rdchk(IDX_STATUS, ZERO, "flag cleared");
		check({7'h00, irq}, ZERO, "irq cleared");
		wait_tick(3);
		rdchk(IDX_STATUS, ZERO, "restart count");
		wait_tick(4);
		rdchk(IDX_STATUS, ONE, "second timeout");
		wr(IDX_MASK, ZERO);
		rdchk(IDX_MASK, ZERO, "mask off");
		check({7'h00, irq}, ZERO, "irq masked");
		preset(ZERO, ZERO, ZERO, ZERO);
		wr(IDX_MASK, ONE);
		go(8'h0B);
		wait_tick(2);
		rdchk(IDX_CONTROL, 8'h0D, "one-shot stops");
		wr(IDX_STATUS, ONE);
		wait_tick(4);
		rdchk(IDX_STATUS, ZERO, "no further timeout");
	endtask

	// second, minute and hour rates each once just short of its carry and once on it
	task automatic rate_select();
		byte_t t;
		byte_t s;
		byte_t m;
		for (int r = 1; r < 4; r++) begin
			for (int p = 0; p < 2; p++) begin
				t = (r == 1 && p == 0) ? 8'h7E : TICK_MAX;
				s = (r == 2 && p == 0) ? 8'h3A : SECOND_MAX;
				m = (r == 3 && p == 0) ? 8'h3A : MINUTE_MAX;
				preset(t, s, m, ZERO);
				wr(IDX_COMPARE, ONE);
				go(byte_t'(8'h03 | (r << 4)));
				wait_tick(1);
				rdchk(IDX_STATUS, (p == 1) ? ONE : ZERO, "rate");
			end
		end
	endtask

	// ----------------------------------------------------------
	// run control
	// ----------------------------------------------------------
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// about twenty ticks are needed; the limit leaves ample room
	initial begin
		repeat (60000) @(posedge pclk);
		bad_count++;
		end_sim();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		xtal_in = 1'b0;
		xcnt = 0;
		cyc = 0;
		t0 = 0;
		bad_count = 0;
		tests_run = 0;
		repeat (20) @(posedge pclk);
		// released by a non-blocking write, so no flop sees it this edge
		presetn <= 1'b1;
		reset_map();
		day_rollover();
		full_hours();
		interval_alarm();
		rate_select();
		end_sim();
	end
endmodule
